// file: logic/asc_pkg.sv
// shared constants and types for the converter sequencing control
package asc_pkg;
    // register word indices; byte address is four times the index
    localparam logic [7:0] ASC_IDX_CLKDIV = 8'hf2;
    localparam logic [7:0] ASC_IDX_CTRL   = 8'hf3;
    localparam logic [7:0] ASC_IDX_LOW    = 8'hf4;
    localparam logic [7:0] ASC_IDX_HIGH   = 8'hf5;
    localparam logic [7:0] ASC_IDX_PINMAP = 8'hf6;
    localparam logic [7:0] ASC_IDX_IRQEN  = 8'hf7;
    localparam logic [7:0] ASC_IDX_STATUS = 8'hf8;
    localparam logic [7:0] ASC_IDX_MASK   = 8'hf9;

    // control and interrupt enable register fields
    localparam int CTL_QUIET = 6;
    localparam int CTL_POWER = 5;
    localparam int CTL_FLAG  = 4;
    localparam int CTL_GO    = 3;
    localparam int SEL_W     = 3;
    localparam int IRQEN_BIT = 1;

    // sticky event status fields
    localparam int ST_DONE    = 0;
    localparam int ST_REFUSED = 1;
    localparam int ST_W       = 2;

    localparam int RES_W     = 10;
    localparam int DIV_W     = 5;
    localparam int CNT_W     = 6;
    localparam int BIT_W     = 4;
    localparam int CONV_TICKS = 11;

    // divider: period is twice the divisor, or 64 clocks when zero
    localparam logic [CNT_W-1:0] ZERO_DIV_LAST = 6'h3f;
    localparam logic [7:0]       REG_RST       = 8'h00;
    localparam logic [RES_W-1:0] RES_RST       = 10'h000;

    typedef enum logic [1:0] {ASC_IDLE, ASC_SAMPLE, ASC_CONVERT} asc_state_t;
endpackage

// file: logic/asc_adc_ctrl.sv
// converter sequencing control with wishbone register slave
// Operation
// - go bit write starts one conversion
// - go bit reads one while busy
// - ready flag set on result, software clears
// - converter interrupt request is flag and enable
// - select field picks analog input zero-seven
// - eleven periods: sample then ten bits
// - code saturates at full scale or zero
// - converter clock divides by twice divisor
// - power bit low puts converter standby
// - quiet mode halts cpu during conversion
// - pin map bit makes pin analog
// - start on digital pin is refused and sets refused status
// - conversion end or standby abort releases halted cpu
//
// Decided for this implementation: register access over Wishbone.
module asc_adc_ctrl
    import asc_pkg::*;
#(
    parameter int ADR_W = 10
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             wb_cyc_in,
    input  wire logic             wb_stb_in,
    input  wire logic             wb_we_in,
    input  wire logic [ADR_W-1:0] wb_adr_in,
    input  wire logic [3:0]       wb_sel_in,
    input  wire logic [31:0]      wb_dat_in,
    output logic      [31:0]      wb_dat_out,
    output logic                  wb_ack_out,
    input  wire logic             comparator_in,
    output logic      [SEL_W-1:0] mux_select_out,
    output logic                  sample_hold_out,
    output logic      [RES_W-1:0] dac_code_out,
    output logic                  converter_power_on_out,
    output logic      [7:0]       analog_pin_map_out,
    output logic                  cpu_halt_out,
    output logic                  converter_irq_out,
    output logic                  irq_out
);
    function automatic logic [CNT_W-1:0] period_last(input logic [DIV_W-1:0] div);
        if (div == '0) begin
            return ZERO_DIV_LAST;
        end
        return CNT_W'({div, 1'b0} - 6'd1);
    endfunction

    asc_state_t       state_q, state_d;
    logic             ack_q, ack_d;
    logic [31:0]      dat_q, dat_d;
    logic [DIV_W-1:0] div_q, div_d;
    logic             quiet_q, quiet_d, power_q, power_d;
    logic             flag_q, flag_d, go_q, go_d;
    logic [SEL_W-1:0] sel_q, sel_d, chan_q, chan_d;
    logic [7:0]       pinmap_q, pinmap_d;
    logic             irqen_q, irqen_d;
    logic [ST_W-1:0]  status_q, status_d, mask_q, mask_d;
    logic [RES_W-1:0] result_q, result_d, trial_q, trial_d;
    logic [BIT_W-1:0] bit_q, bit_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic             sh_q, sh_d, halt_q, halt_d;
    logic             cirq_q, cirq_d, irq_q, irq_d;
    logic             comp_meta_q, comp_sync_q;

    logic             acc, wr, wr_ctrl, start, tick, busy, done;
    logic [7:0]       idx, wbyte;

    assign acc     = wb_cyc_in && wb_stb_in && !ack_q;
    assign wr      = acc && wb_we_in && wb_sel_in[0];
    assign idx     = wb_adr_in[9:2];
    assign wbyte   = wb_dat_in[7:0];
    assign wr_ctrl = wr && idx == ASC_IDX_CTRL;
    assign busy    = state_q != ASC_IDLE;
    // a start needs power and an analog pin; a running one is never restarted
    assign start   = wr_ctrl && wbyte[CTL_GO] && !go_q && wbyte[CTL_POWER]
                     && pinmap_q[wbyte[SEL_W-1:0]];
    assign tick    = busy && cnt_q == period_last(div_q);
    assign done    = state_q == ASC_CONVERT && tick && bit_q == '0 && power_q;

    always_comb begin
        logic [RES_W-1:0] t;
        t        = trial_q;
        state_d  = state_q;
        div_d    = div_q;
        quiet_d  = quiet_q;
        power_d  = power_q;
        flag_d   = flag_q;
        go_d     = go_q;
        sel_d    = sel_q;
        chan_d   = chan_q;
        pinmap_d = pinmap_q;
        irqen_d  = irqen_q;
        status_d = status_q;
        mask_d   = mask_q;
        result_d = result_q;
        trial_d  = trial_q;
        bit_d    = bit_q;
        sh_d     = sh_q;
        halt_d   = halt_q;
        ack_d    = acc;
        dat_d    = '0;
        // divider restarts with each conversion so the first period is whole
        cnt_d    = (start || tick || !busy) ? '0 : CNT_W'(cnt_q + 6'd1);

        if (acc && !wb_we_in) begin
            unique case (idx)
                ASC_IDX_CLKDIV: dat_d[DIV_W-1:0] = div_q;
                ASC_IDX_CTRL:   dat_d[7:0] = {1'b0, quiet_q, power_q, flag_q, go_q, sel_q};
                ASC_IDX_LOW:    dat_d[1:0] = result_q[1:0];
                ASC_IDX_HIGH:   dat_d[7:0] = result_q[RES_W-1:2];
                ASC_IDX_PINMAP: dat_d[7:0] = pinmap_q;
                ASC_IDX_IRQEN:  dat_d[IRQEN_BIT] = irqen_q;
                ASC_IDX_STATUS: dat_d[ST_W-1:0] = status_q;
                ASC_IDX_MASK:   dat_d[ST_W-1:0] = mask_q;
                default:        dat_d = '0;
            endcase
        end

        if (wr) begin
            unique case (idx)
                ASC_IDX_CLKDIV: div_d = wbyte[DIV_W-1:0];
                ASC_IDX_CTRL: begin
                    quiet_d = wbyte[CTL_QUIET];
                    power_d = wbyte[CTL_POWER];
                    sel_d   = wbyte[SEL_W-1:0];
                    if (!wbyte[CTL_FLAG]) begin
                        flag_d = 1'b0;
                    end
                    if (wbyte[CTL_GO] && !start) begin
                        status_d[ST_REFUSED] = 1'b1;
                    end
                end
                ASC_IDX_PINMAP: pinmap_d = wbyte;
                ASC_IDX_IRQEN:  irqen_d = wbyte[IRQEN_BIT];
                ASC_IDX_STATUS: status_d = status_d & ~wbyte[ST_W-1:0];
                ASC_IDX_MASK:   mask_d = wbyte[ST_W-1:0];
                default: ;
            endcase
        end

        unique case (state_q)
            ASC_IDLE: begin
                if (start) begin
                    state_d = ASC_SAMPLE;
                    go_d    = 1'b1;
                    chan_d  = wbyte[SEL_W-1:0];
                    halt_d  = wbyte[CTL_QUIET];
                    sh_d    = 1'b1;
                    trial_d = '0;
                end
            end
            ASC_SAMPLE: begin
                if (tick) begin
                    state_d = ASC_CONVERT;
                    sh_d    = 1'b0;
                    bit_d   = BIT_W'(RES_W - 1);
                    trial_d = '0;
                    trial_d[RES_W-1] = 1'b1;
                end
            end
            ASC_CONVERT: begin
                if (tick) begin
                    // comparator high keeps the trial bit, low drops it
                    if (!comp_sync_q) begin
                        t[bit_q] = 1'b0;
                    end
                    if (bit_q == '0) begin
                        state_d  = ASC_IDLE;
                        result_d = t;
                        go_d     = 1'b0;
                        halt_d   = 1'b0;
                        trial_d  = t;
                    end else begin
                        t[BIT_W'(bit_q - 4'd1)] = 1'b1;
                        trial_d = t;
                        bit_d   = BIT_W'(bit_q - 4'd1);
                    end
                end
            end
        endcase

        // standby aborts a conversion in progress without a result
        if (busy && !power_q) begin
            state_d = ASC_IDLE;
            go_d    = 1'b0;
            halt_d  = 1'b0;
            sh_d    = 1'b0;
        end
        // hardware set wins over a clear in the same cycle
        if (done) begin
            flag_d = 1'b1;
            status_d[ST_DONE] = 1'b1;
        end
        cirq_d = flag_d && irqen_d;
        irq_d  = |(status_d & mask_d);
    end

    always_ff @(posedge clk_in) begin
        comp_meta_q <= comparator_in;
        comp_sync_q <= comp_meta_q;
        if (!rst_n_in) begin
            state_q  <= ASC_IDLE;
            ack_q    <= 1'b0;
            dat_q    <= '0;
            div_q    <= '0;
            quiet_q  <= 1'b0;
            power_q  <= 1'b0;
            flag_q   <= 1'b0;
            go_q     <= 1'b0;
            sel_q    <= '0;
            chan_q   <= '0;
            pinmap_q <= REG_RST;
            irqen_q  <= 1'b0;
            status_q <= '0;
            mask_q   <= '0;
            result_q <= RES_RST;
            trial_q  <= RES_RST;
            bit_q    <= '0;
            cnt_q    <= '0;
            sh_q     <= 1'b0;
            halt_q   <= 1'b0;
            cirq_q   <= 1'b0;
            irq_q    <= 1'b0;
        end else begin
            state_q  <= state_d;
            ack_q    <= ack_d;
            dat_q    <= dat_d;
            div_q    <= div_d;
            quiet_q  <= quiet_d;
            power_q  <= power_d;
            flag_q   <= flag_d;
            go_q     <= go_d;
            sel_q    <= sel_d;
            chan_q   <= chan_d;
            pinmap_q <= pinmap_d;
            irqen_q  <= irqen_d;
            status_q <= status_d;
            mask_q   <= mask_d;
            result_q <= result_d;
            trial_q  <= trial_d;
            bit_q    <= bit_d;
            cnt_q    <= cnt_d;
            sh_q     <= sh_d;
            halt_q   <= halt_d;
            cirq_q   <= cirq_d;
            irq_q    <= irq_d;
        end
    end

    assign wb_dat_out             = dat_q;
    assign wb_ack_out             = ack_q;
    assign mux_select_out         = chan_q;
    assign sample_hold_out        = sh_q;
    assign dac_code_out           = trial_q;
    assign converter_power_on_out = power_q;
    assign analog_pin_map_out     = pinmap_q;
    assign cpu_halt_out           = halt_q;
    assign converter_irq_out      = cirq_q;
    assign irq_out                = irq_q;

    // ticks in this conversion, and clocks since the last tick or start
    logic [BIT_W-1:0] ticks_q;
    logic [CNT_W:0]   gap_q;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || start) begin
            ticks_q <= '0;
        end else if (tick) begin
            ticks_q <= BIT_W'(ticks_q + 4'd1);
        end
        gap_q <= (!rst_n_in || start || tick) ? '0 : (CNT_W+1)'(gap_q + 7'd1);
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_start;
        start |=> go_q && state_q == ASC_SAMPLE && sample_hold_out;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_busy_go;
        busy |-> go_q;
    endproperty
    a_busy_go: assert property (p_busy_go) else $error("go bit low while busy");
    property p_flag_set;
        done |=> flag_q && !go_q && (result_q == {$past(trial_q[RES_W-1:1]), $past(comp_sync_q)});
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag or result wrong at end");
    property p_flag_hold;
        flag_q && !(wr_ctrl && !wbyte[CTL_FLAG]) |=> flag_q;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
    property p_cirq;
        converter_irq_out == (flag_q && irqen_q);
    endproperty
    a_cirq: assert property (p_cirq) else $error("converter request mismatch");
    property p_mux;
        start |=> mux_select_out == $past(wb_dat_in[2:0]);
    endproperty
    a_mux: assert property (p_mux) else $error("wrong input routed");
    property p_eleven;
        done |-> ticks_q == BIT_W'(CONV_TICKS - 1);
    endproperty
    a_eleven: assert property (p_eleven) else $error("conversion not eleven periods");
    property p_div_zero;
        busy && div_q == '0 |-> (gap_q <= {1'b0, ZERO_DIV_LAST}) && (tick == (gap_q == {1'b0, ZERO_DIV_LAST}));
    endproperty
    a_div_zero: assert property (p_div_zero) else $error("divide by 64 wrong");
    property p_standby;
        !power_q && !start |=> state_q == ASC_IDLE && !go_q;
    endproperty
    a_standby: assert property (p_standby) else $error("converter active in standby");
    property p_halt;
        start |=> cpu_halt_out == $past(wbyte[CTL_QUIET]);
    endproperty
    a_halt: assert property (p_halt) else $error("halt not from quiet bit");
    property p_halt_hold;
        cpu_halt_out |-> go_q;
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("halt outlives conversion");
    property p_map;
        wr && idx == ASC_IDX_PINMAP |=> analog_pin_map_out == $past(wbyte);
    endproperty
    a_map: assert property (p_map) else $error("pin map not applied");
    property p_high;
        acc && !wb_we_in && idx == ASC_IDX_HIGH |=> wb_dat_out[7:0] == $past(result_q[RES_W-1:2]);
    endproperty
    a_high: assert property (p_high) else $error("high byte wrong");
    property p_digital;
        wr_ctrl && wbyte[CTL_GO] && !go_q && !pinmap_q[wbyte[SEL_W-1:0]] |=> !go_q;
    endproperty
    a_digital: assert property (p_digital) else $error("start on digital pin");
    property p_no_restart;
        wr_ctrl && wbyte[CTL_GO] && busy && power_q |=> state_q != ASC_SAMPLE || $past(state_q) == ASC_SAMPLE;
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("running conversion restarted");
    c_start: cover property (start);
    c_done: cover property (done);
    c_quiet: cover property (done && cpu_halt_out);
endmodule

// file: verif/asc_analog_model.sv
// analog sources behind the channel multiplexer, seen through the comparator
module asc_analog_model
    import asc_pkg::*;
(
    input  wire logic             clk_in,
    input  wire logic [SEL_W-1:0] mux_select_in,
    input  wire logic [RES_W-1:0] dac_code_in,
    input  wire logic             power_in,
    input  wire logic [87:0]      levels_in,
    output logic                  comparator_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [10:0] lvl;
    logic        toggle_q = 1'b0;

    // a powered-down comparator gives no steady answer
    always_ff @(posedge clk_in) begin
        toggle_q <= ~toggle_q;
    end

    always_comb begin
        lvl = levels_in[mux_select_in*11 +: 11];
        if (lvl > 11'h3ff) begin
            lvl = 11'h3ff;
        end
        comparator_out = power_in ? (lvl >= {1'b0, dac_code_in}) : toggle_q;
    end
endmodule

// file: verif/test_asc_adc_ctrl.sv
// self-checking bench for the converter sequencing control
module test_asc_adc_ctrl;
    import asc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, rst_n_in = 1'b0, cyc = 1'b0, we = 1'b0, comp;
    logic [9:0] adr = 10'h000;
    logic [3:0] sel = 4'h0, wsel = 4'h1;
    logic [31:0] wdat = 32'h0000_0000, rdat;
    logic ack, pwr, halt, cirq, irq, sh;
    logic [2:0] msel;
    logic [9:0] dac;
    logic [7:0] pmap, junk;
    logic [87:0] levels = 88'h0;
    int errors = 0, n_compared = 0;

    asc_adc_ctrl dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we),
        .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
        .comparator_in(comp), .mux_select_out(msel), .sample_hold_out(sh), .dac_code_out(dac),
        .converter_power_on_out(pwr), .analog_pin_map_out(pmap), .cpu_halt_out(halt),
        .converter_irq_out(cirq), .irq_out(irq));
    asc_analog_model src (.clk_in(clk_in), .mux_select_in(msel), .dac_code_in(dac), .power_in(pwr),
        .levels_in(levels), .comparator_out(comp));

    always #12.5 clk_in = ~clk_in;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one classic cycle; ack and read data are taken at the same edge
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] r);
        int n;
        n = 0;
        @(posedge clk_in);
        cyc <= 1'b1;
        we <= w;
        sel <= wsel;
        adr <= {idx, 2'b00};
        wdat <= {24'h00_0000, d};
        do begin
            @(posedge clk_in);
            n++;
        end while (ack !== 1'b1 && n < 50);
        check("ack", {31'h0, ack}, 32'h0000_0001);
        r = rdat[7:0];
        cyc <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, junk);
    endtask

    task automatic rd(input logic [7:0] idx, input string name, input logic [7:0] exp);
        logic [7:0] r;
        bus(1'b0, idx, 8'h00, r);
        check(name, {24'h0, r}, {24'h0, exp});
    endtask

    task automatic wait_irq(output int n);
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (cirq !== 1'b1 && n < 2000);
    endtask

    task automatic t_reset;
        for (int i = 8'hf2; i <= 8'hf9; i++) begin
            rd(i[7:0], "reset value", 8'h00);
        end
        wr(8'hfa, 8'hff);
        rd(8'hfa, "unmapped", 8'h00);
        // a write without its byte lane must leave the register alone
        wsel = 4'h0;
        wr(ASC_IDX_PINMAP, 8'hff);
        wsel = 4'h1;
        rd(ASC_IDX_PINMAP, "no byte lane", 8'h00);
        check("halt idle", {31'h0, halt}, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_convert(input logic [2:0] ch, input logic [10:0] lvl, input logic [9:0] code, input logic [4:0] dv);
        int n, p;
        p = (dv == 5'h00) ? 64 : 2 * dv;
        levels[ch*11 +: 11] = lvl;
        wr(ASC_IDX_CLKDIV, {3'h0, dv});
        wr(ASC_IDX_PINMAP, 8'h01 << ch);
        check("pin map out", {24'h0, pmap}, {24'h0, 8'h01 << ch});
        wr(ASC_IDX_IRQEN, 8'h02);
        wr(ASC_IDX_MASK, 8'h01);
        wr(ASC_IDX_CTRL, {5'h05, ch});
        wait_irq(n);
        check("conversion time", n, 11 * p);
        check("irq line", {31'h0, irq}, 32'h0000_0001);
        rd(ASC_IDX_CTRL, "flag set go clear", {5'h06, ch});
        rd(ASC_IDX_HIGH, "high byte", code[9:2]);
        rd(ASC_IDX_LOW, "low byte", {6'h00, code[1:0]});
        wr(ASC_IDX_CTRL, {5'h04, ch});
        wr(ASC_IDX_STATUS, 8'h01);
        repeat (2) @(posedge clk_in);
        check("irq rearmed", {30'h0, cirq, irq}, 32'h0000_0000);
        rd(ASC_IDX_CTRL, "flag cleared", {5'h04, ch});
        $display("test convert channel %0d done", ch);
    endtask

    task automatic t_busy;
        int n;
        levels[33 +: 11] = 11'h155;
        wr(ASC_IDX_CLKDIV, 8'h02);
        wr(ASC_IDX_PINMAP, 8'h08);
        wr(ASC_IDX_CTRL, 8'h6b);
        check("channel routed", {29'h0, msel}, 32'h0000_0003);
        check("sample hold", {31'h0, sh}, 32'h0000_0001);
        rd(ASC_IDX_CTRL, "busy", 8'h6b);
        check("cpu halted", {31'h0, halt}, 32'h0000_0001);
        wr(ASC_IDX_CTRL, 8'h6b);
        rd(ASC_IDX_STATUS, "second go refused", 8'h02);
        wait_irq(n);
        // the wait begins ten clocks after the start; a restart would stretch it
        check("busy conversion time", n, 11 * 4 - 9);
        check("trial code", {22'h0, dac}, {22'h0, 10'h155});
        rd(ASC_IDX_HIGH, "high after restart try", 8'h55);
        rd(ASC_IDX_LOW, "low after restart try", 8'h01);
        check("cpu released", {31'h0, halt}, 32'h0000_0000);
        wr(ASC_IDX_CTRL, 8'h23);
        wr(ASC_IDX_STATUS, 8'h03);
        $display("test busy done");
    endtask

    task automatic t_refuse;
        wr(ASC_IDX_PINMAP, 8'hfd);
        wr(ASC_IDX_MASK, 8'h00);
        wr(ASC_IDX_CTRL, 8'h29);
        repeat (60) @(posedge clk_in);
        rd(ASC_IDX_CTRL, "digital pin no start", 8'h21);
        rd(ASC_IDX_STATUS, "refused status", 8'h02);
        check("masked", {31'h0, irq}, 32'h0000_0000);
        wr(ASC_IDX_MASK, 8'h02);
        @(posedge clk_in);
        check("unmasked", {31'h0, irq}, 32'h0000_0001);
        wr(ASC_IDX_STATUS, 8'h02);
        @(posedge clk_in);
        check("cleared", {31'h0, irq}, 32'h0000_0000);
        wr(ASC_IDX_PINMAP, 8'h02);
        wr(ASC_IDX_CTRL, 8'h09);
        check("standby", {31'h0, pwr}, 32'h0000_0000);
        rd(ASC_IDX_CTRL, "no start unpowered", 8'h01);
        rd(ASC_IDX_STATUS, "unpowered refused", 8'h02);
        wr(ASC_IDX_STATUS, 8'h02);
        // power off in mid-conversion drops it without a result
        wr(ASC_IDX_CTRL, 8'h21);
        repeat (20) @(posedge clk_in);
        wr(ASC_IDX_CTRL, 8'h29);
        wr(ASC_IDX_CTRL, 8'h01);
        repeat (60) @(posedge clk_in);
        rd(ASC_IDX_CTRL, "aborted in standby", 8'h01);
        rd(ASC_IDX_STATUS, "no result after abort", 8'h00);
        $display("test refuse done");
    endtask

    initial begin
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_reset();
        wr(ASC_IDX_CTRL, 8'h20);
        // settling time after power on before the first start
        repeat (20) @(posedge clk_in);
        t_convert(3'd0, 11'h000, 10'h000, 5'h02);
        t_convert(3'd7, 11'h5dc, 10'h3ff, 5'h03);
        t_convert(3'd3, 11'h2a5, 10'h2a5, 5'h00);
        t_busy();
        t_refuse();
        complete_run();
    end

    initial begin
        #(20000 * 25);
        errors++;
        complete_run();
    end
endmodule
